//--- common/tmrop_regs.vh
// constants for the timer0 / watchdog option control block
// assumes a plain address/strobe register port, one clock domain
`ifndef TMROP_REGS_VH
`define TMROP_REGS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define TMROP_ADDR_W 3
`define TMROP_A_OPTION 3'h0
`define TMROP_A_COUNT 3'h1
`define TMROP_A_STATUS 3'h2
`define TMROP_A_MASK 3'h3
`define TMROP_A_PULLUP 3'h4
`define TMROP_A_WDT 3'h5

// ----------------------------------------
// option register fields and reset
// ----------------------------------------
`define TMROP_OPT_RESET 8'hff
`define TMROP_B_PULLUP_DIS 7
`define TMROP_B_IRQ_EDGE 6
`define TMROP_B_CLK_SRC 5
`define TMROP_B_SRC_EDGE 4
`define TMROP_B_OWNER 3
`define TMROP_RATE_HI 2
`define TMROP_RATE_LO 0

// ----------------------------------------
// status bits and misc
// ----------------------------------------
`define TMROP_ST_W 3
`define TMROP_ST_OVF 0
`define TMROP_ST_EXT 1
`define TMROP_ST_WDT 2
`define TMROP_COUNT_MAX 8'hff
`define TMROP_ZERO8 8'h00
`define TMROP_ZERO3 3'h0
`define TMROP_PIN_W 8

`endif

//--- hdl/tmrop_option_ctrl.v
// option control block: timer0 clock/edge, shared prescaler, ext irq edge, pull-up gate
// assumes synchronous reset, one clock, pins asynchronous and synchronised here
// Contract
// - option bit 7 high disables all pull-ups; low enables those individually enabled
// - option bit 6 low: rising external edge interrupts; high: falling edge
// - option bit 5 high clocks timer from pin edges, low from cycle clock
// - option bit 4 high counts falling pin edges, low counts rising ones
// - option bit 3 high gives prescaler to watchdog, low to timer
// - rate bits divide timer 2 to 256, watchdog 1 to 128
// - prescaler with watchdog leaves timer undivided at 1:1
// - all option bits read/write, reset value all ones
`timescale 1ns/1ps
`include "tmrop_regs.vh"
`default_nettype none

module tmrop_option_ctrl (
	input wire i_clk,
	input wire i_rst,
	input wire [`TMROP_ADDR_W-1:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	input wire i_timer_zero_ext_clock_pin,
	input wire i_ext_irq_pin,
	input wire i_wdt_tick,
	output reg [7:0] o_rdata,
	output reg [`TMROP_PIN_W-1:0] o_pullup_active,
	output reg o_wdt_timeout,
	output reg o_irq
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// prescaler tap: all ones in the low bits ends one division period
	function [7:0] tmrop_div_mask;
		input [2:0] rate;
		input wdt_owner;
		begin
			// timer 1:2 at code 0 needs one count bit; watchdog one fewer
			tmrop_div_mask = wdt_owner ? ((8'h01 << rate) - 8'h01) : ((8'h02 << rate) - 8'h01);
		end
	endfunction

	// address match, shared by every strobe decoder
	function tmrop_hit;
		input [`TMROP_ADDR_W-1:0] addr;
		input [`TMROP_ADDR_W-1:0] target;
		begin
			tmrop_hit = (addr == target);
		end
	endfunction

	// ----------------------------------------
	// local sizes
	// ----------------------------------------
	localparam SYNC_N = 2;
	localparam PIN_TCK = 0;
	localparam PIN_IRQ = 1;

	// ----------------------------------------
	// synchronisers and edge detect
	// ----------------------------------------
	// both pins are asynchronous; the third flop only feeds edge detect
	wire [SYNC_N-1:0] pin_in;
	wire [SYNC_N-1:0] pin_rise;
	wire [SYNC_N-1:0] pin_fall;
	assign pin_in[PIN_TCK] = i_timer_zero_ext_clock_pin;
	assign pin_in[PIN_IRQ] = i_ext_irq_pin;

	genvar g;
	generate
		for (g = 0; g < SYNC_N; g = g + 1) begin : g_sync
			reg meta_r;
			reg stab_r;
			reg prev_r;
			always @(posedge i_clk) begin
				if (i_rst) begin
					meta_r <= 1'b0;
					stab_r <= 1'b0;
					prev_r <= 1'b0;
				end else begin
					meta_r <= pin_in[g];
					stab_r <= meta_r;
					prev_r <= stab_r;
				end
			end
			assign pin_rise[g] = stab_r & ~prev_r;
			assign pin_fall[g] = ~stab_r & prev_r;
		end
	endgenerate

	// ----------------------------------------
	// option register fields
	// ----------------------------------------
	reg [7:0] option_r;
	wire port_pullup_disable = option_r[`TMROP_B_PULLUP_DIS];
	wire ext_irq_edge_select = option_r[`TMROP_B_IRQ_EDGE];
	wire timer_zero_clock_source_sel = option_r[`TMROP_B_CLK_SRC];
	wire timer_zero_edge_sel = option_r[`TMROP_B_SRC_EDGE];
	wire prescaler_owner_sel = option_r[`TMROP_B_OWNER];
	wire [2:0] prescaler_rate_sel = option_r[`TMROP_RATE_HI:`TMROP_RATE_LO];

	// ----------------------------------------
	// strobe decode
	// ----------------------------------------
	wire wr_option = i_wr && tmrop_hit(i_addr, `TMROP_A_OPTION);
	wire wr_count = i_wr && tmrop_hit(i_addr, `TMROP_A_COUNT);
	wire wr_mask = i_wr && tmrop_hit(i_addr, `TMROP_A_MASK);
	wire wr_pullup = i_wr && tmrop_hit(i_addr, `TMROP_A_PULLUP);
	wire wr_wdt = i_wr && tmrop_hit(i_addr, `TMROP_A_WDT);
	wire rd_status = i_rd && tmrop_hit(i_addr, `TMROP_A_STATUS);

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [7:0] count_r;
	reg [7:0] presc_r;
	reg [7:0] wdt_cnt_r;
	reg [`TMROP_ST_W-1:0] status_r;
	reg [`TMROP_ST_W-1:0] mask_r;
	reg [`TMROP_PIN_W-1:0] pin_pullup_enable_r;
	reg [7:0] count_nxt;
	reg [7:0] presc_nxt;
	reg [7:0] wdt_cnt_nxt;
	reg [`TMROP_ST_W-1:0] status_nxt;

	// ----------------------------------------
	// event selection
	// ----------------------------------------
	wire tck_evt = timer_zero_edge_sel ? pin_fall[PIN_TCK] : pin_rise[PIN_TCK];
	wire tmr_src_evt = timer_zero_clock_source_sel ? tck_evt : 1'b1;
	wire ext_evt = ext_irq_edge_select ? pin_fall[PIN_IRQ] : pin_rise[PIN_IRQ];

	// one prescaler only: whichever side does not own it runs undivided
	wire presc_in = prescaler_owner_sel ? i_wdt_tick : tmr_src_evt;
	wire [7:0] div_mask = tmrop_div_mask(prescaler_rate_sel, prescaler_owner_sel);
	wire presc_out = presc_in & ((presc_r & div_mask) == div_mask);
	wire tmr_inc = prescaler_owner_sel ? tmr_src_evt : presc_out;
	wire wdt_inc = prescaler_owner_sel ? presc_out : i_wdt_tick;

	// a write that reloads a counter hides the wrap it would have made
	wire tmr_ovf = tmr_inc && !wr_count && (count_r == `TMROP_COUNT_MAX);
	wire wdt_ovf = wdt_inc && !wr_wdt && (wdt_cnt_r == `TMROP_COUNT_MAX);
	wire [`TMROP_ST_W-1:0] st_set = {wdt_ovf, ext_evt, tmr_ovf};

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	// writing the count or the option restarts the prescaler
	always @* begin
		if (wr_count || wr_option)
			presc_nxt = `TMROP_ZERO8;
		else if (presc_in)
			presc_nxt = presc_r + 8'h01;
		else
			presc_nxt = presc_r;
	end

	always @* begin
		if (wr_count)
			count_nxt = i_wdata;
		else if (tmr_inc)
			count_nxt = count_r + 8'h01;
		else
			count_nxt = count_r;
	end

	always @* begin
		if (wr_wdt)
			wdt_cnt_nxt = `TMROP_ZERO8;
		else if (wdt_inc)
			wdt_cnt_nxt = wdt_cnt_r + 8'h01;
		else
			wdt_cnt_nxt = wdt_cnt_r;
	end

	// a new event beats the read-clear
	always @* begin
		status_nxt = (rd_status ? `TMROP_ZERO3 : status_r) | st_set;
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always @(posedge i_clk) begin
		if (i_rst) begin
			option_r <= `TMROP_OPT_RESET;
		end else if (wr_option) begin
			option_r <= i_wdata;
		end
	end

	always @(posedge i_clk) begin
		if (i_rst) begin
			mask_r <= `TMROP_ZERO3;
		end else if (wr_mask) begin
			mask_r <= i_wdata[`TMROP_ST_W-1:0];
		end
	end

	always @(posedge i_clk) begin
		if (i_rst) begin
			pin_pullup_enable_r <= `TMROP_ZERO8;
		end else if (wr_pullup) begin
			pin_pullup_enable_r <= i_wdata;
		end
	end

	// ----------------------------------------
	// counters and status
	// ----------------------------------------
	always @(posedge i_clk) begin
		if (i_rst) begin
			presc_r <= `TMROP_ZERO8;
		end else begin
			presc_r <= presc_nxt;
		end
	end

	always @(posedge i_clk) begin
		if (i_rst) begin
			count_r <= `TMROP_ZERO8;
		end else begin
			count_r <= count_nxt;
		end
	end

	always @(posedge i_clk) begin
		if (i_rst) begin
			wdt_cnt_r <= `TMROP_ZERO8;
		end else begin
			wdt_cnt_r <= wdt_cnt_nxt;
		end
	end

	always @(posedge i_clk) begin
		if (i_rst) begin
			status_r <= `TMROP_ZERO3;
		end else begin
			status_r <= status_nxt;
		end
	end

	// ----------------------------------------
	// pin and event outputs
	// ----------------------------------------
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_pullup_active <= `TMROP_ZERO8;
		end else begin
			o_pullup_active <= port_pullup_disable ? `TMROP_ZERO8 : pin_pullup_enable_r;
		end
	end

	always @(posedge i_clk) begin
		if (i_rst) begin
			o_wdt_timeout <= 1'b0;
		end else begin
			o_wdt_timeout <= wdt_ovf;
		end
	end

	// built from the status being stored, so a set that meets a read-clear still shows
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(status_nxt & mask_r);
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	// idle read data is zero so a stale value never looks like an answer
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= `TMROP_ZERO8;
		end else if (i_rd) begin
			case (i_addr)
			`TMROP_A_OPTION: o_rdata <= option_r;
			`TMROP_A_COUNT: o_rdata <= count_r;
			`TMROP_A_STATUS: o_rdata <= {5'h00, status_r};
			`TMROP_A_MASK: o_rdata <= {5'h00, mask_r};
			`TMROP_A_PULLUP: o_rdata <= pin_pullup_enable_r;
			`TMROP_A_WDT: o_rdata <= wdt_cnt_r;
			default: o_rdata <= `TMROP_ZERO8;
			endcase
		end else begin
			o_rdata <= `TMROP_ZERO8;
		end
	end

endmodule // tmrop_option_ctrl
`default_nettype wire

//--- bench/tmrop_assertions.sv
// port checker for the option control block
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module tmrop_assertions (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_timer_zero_ext_clock_pin,
	input wire logic i_ext_irq_pin,
	input wire logic i_wdt_tick,
	input wire logic [7:0] o_rdata,
	input wire logic [7:0] o_pullup_active,
	input wire logic o_wdt_timeout,
	input wire logic o_irq
);
default clocking @(posedge i_clk); endclocking
default disable iff (i_rst);
property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
property p_rst_val; $past(i_rst) && i_rd && i_addr == 3'h0 |=> o_rdata == 8'hff; endproperty
a_rst_val: assert property (p_rst_val) else $error("option reset value");
property p_wr_rd; i_wr && i_addr == 3'h0 ##1 i_rd && i_addr == 3'h0 |=> o_rdata == $past(i_wdata, 2); endproperty
a_wr_rd: assert property (p_wr_rd) else $error("option readback");
property p_unmapped; i_rd && i_addr > 3'h5 |=> o_rdata == 8'h00; endproperty
a_unmapped: assert property (p_unmapped) else $error("unmapped read");
property p_pu_off; i_wr && i_addr == 3'h0 && i_wdata[7] |-> ##2 o_pullup_active == 8'h00; endproperty
a_pu_off: assert property (p_pu_off) else $error("pull-ups not gated off");
property p_pu_on; i_wr && i_addr == 3'h4 ##1 i_wr && i_addr == 3'h0 && !i_wdata[7]
	|-> ##2 o_pullup_active == $past(i_wdata, 3); endproperty
a_pu_on: assert property (p_pu_on) else $error("pull-ups not passed");
property p_cnt_wr; i_wr && i_addr == 3'h1 ##1 i_rd && i_addr == 3'h1 |=> (o_rdata - $past(i_wdata, 2)) <= 8'h01; endproperty
a_cnt_wr: assert property (p_cnt_wr) else $error("count reload");
property p_wdt_pulse; o_wdt_timeout |=> !o_wdt_timeout; endproperty
a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog pulse too long");
endmodule // tmrop_assertions
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the option control block
// assumes the design ports as declared, one 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t %h %h", $time, a, b); end end
module testbench;
logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_wdt_tick = 1, tpin = 0, ipin = 0;
logic [2:0] i_addr = 0;
logic [7:0] i_wdata = 0, o_rdata, o_pullup_active, a, b, c;
logic o_wdt_timeout, o_irq;
logic [1:0] q;
int fail_count = 0, tests_run = 0, k;
always #20 i_clk = ~i_clk;
tmrop_option_ctrl i_tmrop_option_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_rd(i_rd), .i_timer_zero_ext_clock_pin(tpin), .i_ext_irq_pin(ipin), .i_wdt_tick(i_wdt_tick),
	.o_rdata(o_rdata), .o_pullup_active(o_pullup_active), .o_wdt_timeout(o_wdt_timeout), .o_irq(o_irq));
// w, wr and rd each start just after a rising edge and return just after one
task automatic w(input int n);
	i_wr <= 0;
	i_rd <= 0;
	repeat (n) @(posedge i_clk);
endtask
// write strobe is left high so a following write keeps it up; w or rd drops it
task automatic wr(input logic [2:0] ad, input logic [7:0] d);
	i_addr <= ad;
	i_wdata <= d;
	i_rd <= 0;
	i_wr <= 1;
	@(posedge i_clk);
endtask
// read data stand in the cycle after the strobe; taken mid-cycle
task automatic rd(input logic [2:0] ad, output logic [7:0] v);
	i_addr <= ad;
	i_wr <= 0;
	i_rd <= 1;
	@(posedge i_clk);
	i_rd <= 0;
	@(negedge i_clk);
	v = o_rdata;
	@(posedge i_clk);
endtask
task automatic finish_test;
	$display("checks %0d mismatches %0d", tests_run, fail_count);
	if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
	else $display("Simulation failed");
	$finish;
endtask
initial begin
	#1000000 fail_count++;
	finish_test;
end
initial begin
	w(2);
	i_rst <= 0;
	rd(0, a);
	`CHK(a, 8'hff)
	rd(6, a);
	`CHK(a, 8'h00)
	wr(0, 8'ha5);
	rd(0, a);
	`CHK(a, 8'ha5)
	wr(4, 8'h3c);
	wr(0, 8'h00);
	w(3);
	`CHK(o_pullup_active, 8'h3c)
	wr(0, 8'h80);
	w(3);
	`CHK(o_pullup_active, 8'h00)
	// every rate code, then owner=watchdog for the undivided case; load near max to wrap
	for (int i = 0; i < 9; i++) begin
		wr(0, (i < 8) ? i[7:0] : 8'h08);
		wr(1, 8'hfe);
		rd(1, a);
		w(((i < 8) ? 8 << i : 9) - 1);
		rd(1, b);
		`CHK(b - a, (i < 8) ? 8'h04 : 8'h0a)
	end
	for (int e = 0; e < 2; e++) begin
		wr(0, e ? 8'h38 : 8'h28);
		rd(1, a);
		tpin <= 1;
		w(6);
		rd(1, b);
		tpin <= 0;
		w(6);
		rd(1, c);
		`CHK(b - a, e ? 8'h00 : 8'h01)
		`CHK(c - b, e ? 8'h01 : 8'h00)
	end
	// watchdog owns the prescaler at code 1: one count per two ticks
	wr(0, 8'h09);
	wr(5, 8'h00);
	rd(5, a);
	w(14);
	rd(5, b);
	`CHK(b - a, 8'h08)
	// unprescaled watchdog wraps after 256 ticks; bounded watch for the pulse
	wr(0, 8'h00);
	wr(5, 8'h00);
	i_wr <= 0;
	for (k = 0; k < 300 && !o_wdt_timeout; k++) @(negedge i_clk);
	@(posedge i_clk);
	`CHK(k, 257)
	// ext source with a still pin keeps the overflow flag quiet here
	i_wdt_tick <= 0;
	for (int e = 0; e < 2; e++) begin
		wr(3, e ? 8'h07 : 8'h00);
		wr(0, e ? 8'h68 : 8'h28);
		ipin <= e[0];
		w(6);
		rd(2, a);
		ipin <= ~e[0];
		w(6);
		q[e] = o_irq;
		rd(2, b);
		`CHK(b[1], 1'b1)
		ipin <= e[0];
		w(6);
		rd(2, c);
		`CHK(c[1], 1'b0)
		w(2);
		`CHK(o_irq, 1'b0)
	end
	`CHK(q[0] ^ q[1], 1'b1)
	finish_test;
end
endmodule // testbench
bind tmrop_option_ctrl tmrop_assertions i_tmrop_assertions (.*);
`default_nettype wire
